/* File: shared/ilo_defines.vh */
// offsets, field positions, reset values and opcode patterns of the indexed offset decoder
`ifndef ILO_DEFINES_VH
`define ILO_DEFINES_VH

`define ILO_OFS_CTRL 8'h00
`define ILO_OFS_SFP 8'h04
`define ILO_OFS_ACC 8'h08
`define ILO_OFS_BSR 8'h0C
`define ILO_OFS_STATUS 8'h10
`define ILO_OFS_INSTR 8'h14
`define ILO_OFS_EADDR 8'h18
`define ILO_OFS_MEM_ADDR 8'h1C
`define ILO_OFS_MEM_DATA 8'h20

`define ILO_RST_CTRL 1'h0
`define ILO_RST_SFP 12'h000
`define ILO_RST_ACC 8'h00
`define ILO_RST_BSR 4'h0
`define ILO_RST_FLAGS 5'h00
`define ILO_RST_INSTR 16'h0000

`define ILO_BIT_C 0
`define ILO_BIT_DC 1
`define ILO_BIT_Z 2
`define ILO_BIT_OV 3
`define ILO_BIT_N 4
`define ILO_BIT_BUSY 5
`define ILO_BIT_BADOP 6
`define ILO_BIT_INDEXED 12

`define ILO_OFFSET_MAX 8'h5F
`define ILO_ACCESS_SPLIT 8'h80
`define ILO_ACCESS_HIGH_BANK 4'hF
`define ILO_ACCESS_LOW_BANK 4'h0
`define ILO_ALL_ONES 8'hFF

`define ILO_OP_ADD 6'h09
`define ILO_OP_BSET 4'h8
`define ILO_OP_SETALL 7'h34

`endif

/* File: verilog/ilo_decode.v */
// indexed literal offset decode and execute unit with apb register access
`timescale 1ns/100ps
`include "ilo_defines.vh"

module ilo_decode (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_Q1 = 5'h02;
  localparam [4:0] ST_Q2 = 5'h04;
  localparam [4:0] ST_Q3 = 5'h08;
  localparam [4:0] ST_Q4 = 5'h10;

  localparam [1:0] K_NONE = 2'h0;
  localparam [1:0] K_ADD = 2'h1;
  localparam [1:0] K_BSET = 2'h2;
  localparam [1:0] K_SETALL = 2'h3;

  reg [7:0] mem [0:4095];

  reg ext_en;
  reg [11:0] stack_frame_pointer;
  reg [7:0] acc;
  reg [3:0] bank_select_register;
  reg [4:0] flags;
  reg [15:0] instr;
  reg [11:0] mem_addr;
  reg [4:0] state;
  reg [1:0] kind;
  reg indexed;
  reg [11:0] eaddr;
  reg [7:0] opnd;
  reg [7:0] result;
  reg [4:0] res_flags;
  reg to_acc;
  reg bad_op;

  reg [4:0] next_state;
  reg [1:0] dec_kind;
  reg dec_indexed;
  reg [11:0] dec_eaddr;
  reg [8:0] sum;
  reg [4:0] nib_sum;
  reg [7:0] next_result;
  reg [4:0] next_flags;
  reg [31:0] rd_value;
  reg rd_valid;

  wire busy = ~state[0];
  wire [7:0] fld = instr[7:0];
  wire acc_bit = instr[8];
  wire apb_access = psel & penable & ~pready;
  wire hit_instr = paddr == `ILO_OFS_INSTR;
  wire hit_mem = paddr == `ILO_OFS_MEM_DATA;
  // hold off data memory accesses and instruction writes while the execute path is busy
  wire stall = busy & ((hit_instr & pwrite) | hit_mem);
  wire wr_done = psel & penable & pready & pwrite;
  wire exec_write = state[4] & (kind != K_NONE) & ~to_acc;

  // opcode classification
  always @*
  begin
    dec_kind = K_NONE;
    if (instr[15:10] == `ILO_OP_ADD)
      dec_kind = K_ADD;
    else if (instr[15:12] == `ILO_OP_BSET)
      dec_kind = K_BSET;
    else if (instr[15:9] == `ILO_OP_SETALL)
      dec_kind = K_SETALL;
  end

  // effective address formation
  always @*
  begin
    dec_indexed = ext_en & ~acc_bit & (fld <= `ILO_OFFSET_MAX);
    if (dec_indexed)
      dec_eaddr = stack_frame_pointer + {4'h0, fld};
    else if (acc_bit)
      dec_eaddr = {bank_select_register, fld};
    else if (fld < `ILO_ACCESS_SPLIT)
      dec_eaddr = {`ILO_ACCESS_LOW_BANK, fld};
    else
      dec_eaddr = {`ILO_ACCESS_HIGH_BANK, fld};
  end

  // process data
  always @*
  begin
    sum = {1'b0, acc} + {1'b0, opnd};
    nib_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
    next_result = opnd;
    next_flags = flags;
    case (kind)
      K_ADD:
      begin
        next_result = sum[7:0];
        next_flags[`ILO_BIT_C] = sum[8];
        next_flags[`ILO_BIT_DC] = nib_sum[4];
        next_flags[`ILO_BIT_Z] = sum[7:0] == 8'h00;
        next_flags[`ILO_BIT_OV] = (acc[7] == opnd[7]) & (sum[7] != acc[7]);
        next_flags[`ILO_BIT_N] = sum[7];
      end
      K_BSET:
        next_result = opnd | (8'h01 << instr[11:9]);
      K_SETALL:
        next_result = `ILO_ALL_ONES;
      default:
        next_result = opnd;
    endcase
  end

  // four phase sequence, one instruction cycle
  always @*
  begin
    case (state)
      ST_IDLE:
        next_state = (wr_done & hit_instr) ? ST_Q1 : ST_IDLE;
      ST_Q1:
        next_state = ST_Q2;
      ST_Q2:
        next_state = ST_Q3;
      ST_Q3:
        next_state = ST_Q4;
      ST_Q4:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      kind <= K_NONE;
      indexed <= 1'b0;
      eaddr <= 12'h000;
      opnd <= 8'h00;
      result <= 8'h00;
      res_flags <= `ILO_RST_FLAGS;
      to_acc <= 1'b0;
      bad_op <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      if (state[1])
      begin
        kind <= dec_kind;
        indexed <= dec_indexed;
        eaddr <= dec_eaddr;
        bad_op <= dec_kind == K_NONE;
        to_acc <= (dec_kind == K_ADD) & ~instr[9];
      end
      if (state[2])
        opnd <= mem[eaddr];
      if (state[3])
      begin
        result <= next_result;
        res_flags <= next_flags;
      end
    end
  end

  // software registers; the frame pointer moves only by a bus write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_en <= `ILO_RST_CTRL;
      stack_frame_pointer <= `ILO_RST_SFP;
      acc <= `ILO_RST_ACC;
      bank_select_register <= `ILO_RST_BSR;
      flags <= `ILO_RST_FLAGS;
      instr <= `ILO_RST_INSTR;
      mem_addr <= 12'h000;
    end
    else if (ce)
    begin
      if (wr_done)
      begin
        case (paddr)
          `ILO_OFS_CTRL:
            ext_en <= pwdata[0];
          `ILO_OFS_SFP:
            stack_frame_pointer <= pwdata[11:0];
          `ILO_OFS_BSR:
            bank_select_register <= pwdata[3:0];
          `ILO_OFS_MEM_ADDR:
            mem_addr <= pwdata[11:0];
          `ILO_OFS_INSTR:
            instr <= pwdata[15:0];
          default:
            mem_addr <= mem_addr;
        endcase
      end
      // the core's write of the accumulator and flags wins over a bus write
      if (state[4] & (kind == K_ADD))
      begin
        flags <= res_flags;
        if (to_acc)
          acc <= result;
        else if (wr_done & (paddr == `ILO_OFS_ACC))
          acc <= pwdata[7:0];
      end
      else
      begin
        if (wr_done & (paddr == `ILO_OFS_ACC))
          acc <= pwdata[7:0];
        if (wr_done & (paddr == `ILO_OFS_STATUS))
          flags <= pwdata[4:0];
      end
    end
  end

  // data memory: no reset, a plain array
  always @(posedge pclk)
  begin
    if (ce)
    begin
      if (exec_write)
        mem[eaddr] <= result;
      else if (wr_done & hit_mem)
        mem[mem_addr] <= pwdata[7:0];
    end
  end

  // read mux
  always @*
  begin
    rd_valid = 1'b1;
    rd_value = 32'h00000000;
    case (paddr)
      `ILO_OFS_CTRL:
        rd_value[0] = ext_en;
      `ILO_OFS_SFP:
        rd_value[11:0] = stack_frame_pointer;
      `ILO_OFS_ACC:
        rd_value[7:0] = acc;
      `ILO_OFS_BSR:
        rd_value[3:0] = bank_select_register;
      `ILO_OFS_STATUS:
      begin
        rd_value[4:0] = flags;
        rd_value[`ILO_BIT_BUSY] = busy;
        rd_value[`ILO_BIT_BADOP] = bad_op;
      end
      `ILO_OFS_INSTR:
        rd_value[15:0] = instr;
      `ILO_OFS_EADDR:
      begin
        rd_value[11:0] = eaddr;
        rd_value[`ILO_BIT_INDEXED] = indexed;
      end
      `ILO_OFS_MEM_ADDR:
        rd_value[11:0] = mem_addr;
      `ILO_OFS_MEM_DATA:
        rd_value[7:0] = mem[mem_addr];
      default:
        rd_valid = 1'b0;
    endcase
  end

  // apb answer: one wait state, longer for a data memory access or an instruction write while busy
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (ce)
    begin
      if (apb_access & ~stall)
      begin
        pready <= 1'b1;
        pslverr <= ~rd_valid;
        prdata <= pwrite ? 32'h00000000 : rd_value;
      end
      else
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
    end
  end

endmodule

/* File: tb/ilo_decode_properties.sv */
// port assertions for the indexed offset decoder
`timescale 1ns/100ps
module ilo_decode_properties (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd_ok = pready && !pwrite;
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready stuck");
  chk_ready_cause: assert property (pready |-> psel && penable) else $error("stray pready");
  chk_ready_late: assert property ($rose(penable) |-> !pready) else $error("early pready");
  chk_ready_bound: assert property (psel && penable && !pready |-> ##[1:6] pready) else $error("no pready");
  chk_data_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  chk_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  chk_eaddr_width: assert property (rd_ok && paddr == 8'h18 |-> prdata[31:13] == 19'h0) else $error("eaddr");
  chk_status_width: assert property (rd_ok && paddr == 8'h10 |-> prdata[31:7] == 25'h0) else $error("status");
  cover property (pready && pslverr);
  cover property (pready && pwrite && paddr == 8'h14);
  cover property (rd_ok && paddr == 8'h18);
endmodule
bind ilo_decode ilo_decode_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* File: tb/ilo_decode_tb.sv */
// self-checking bench for the indexed offset decoder
`timescale 1ns/100ps
module ilo_decode_tb;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg ce = 1'b1;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  reg [31:0] rd;
  reg er;
  int mismatches = 0;
  int checks = 0;
  always #12.5 pclk = ~pclk;
  ilo_decode uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input reg [7:0] a, input reg [31:0] got, input reg [31:0] exp);
    begin
      checks++;
      if (got !== exp)
      begin
        mismatches++;
        $display("[ERR] reg %h expected %h seen %h", a, exp, got);
      end
    end
  endtask
  task automatic apb(input reg w, input reg [7:0] a, input reg [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle cycle keeps psel from being driven twice in one step
      @(posedge pclk);
    end
  endtask
  task automatic wr(input reg [7:0] a, input reg [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input reg [7:0] a, input reg [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(a, rd, e);
    end
  endtask
  // status read lets the four phases run out before results are read
  task automatic exec(input reg [15:0] op);
    begin
      wr(8'h14, {16'h0, op});
      apb(1'b0, 8'h10, 32'h0);
    end
  endtask
  task automatic addc(input reg [11:0] f, input reg [7:0] a, m, input reg [15:0] op, input reg [7:0] ea, em, es);
    reg [11:0] ma;
    begin
      ma = f + {4'h0, op[7:0]};
      wr(8'h04, {20'h0, f});
      wr(8'h08, {24'h0, a});
      wr(8'h1C, {20'h0, ma});
      wr(8'h20, {24'h0, m});
      exec(op);
      rc(8'h08, {24'h0, ea});
      rc(8'h20, {24'h0, em});
      rc(8'h10, {24'h0, es});
      rc(8'h18, {20'h1, ma});
    end
  endtask
  task automatic bits_and_fill;
    begin
      wr(8'h04, 32'hA00);
      wr(8'h1C, 32'hA0A);
      wr(8'h20, 32'h0);
      wr(8'h10, 32'h15);
      for (int b = 0; b < 8; b++)
      begin
        exec({4'h8, b[2:0], 9'h00A});
        rc(8'h20, (32'h2 << b) - 32'h1);
      end
      rc(8'h10, 32'h15);
      // clear the byte so the fill is visible
      wr(8'h20, 32'h0);
      exec(16'h680A);
      rc(8'h20, 32'hFF);
      rc(8'h10, 32'h15);
    end
  endtask
  task automatic absolute;
    begin
      wr(8'h00, 32'h0);
      exec(16'h6830);
      rc(8'h18, 32'h030);
      wr(8'h00, 32'h1);
      exec(16'h6860);
      rc(8'h18, 32'h060);
      wr(8'h0C, 32'h5);
      exec(16'h6950);
      rc(8'h18, 32'h550);
      exec(16'h6890);
      rc(8'h18, 32'hF90);
      rc(8'h04, 32'hA00);
    end
  endtask
  // with ce low the four phases must not advance
  task automatic freeze;
    begin
      wr(8'h14, 32'h6890);
      ce <= 1'b0;
      repeat (6) @(posedge pclk);
      ce <= 1'b1;
      rc(8'h10, 32'h35);
      rc(8'h10, 32'h15);
      rc(8'h18, 32'hF90);
    end
  endtask
  task automatic report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(8'h00, 32'h0);
    wr(8'h00, 32'h1);
    addc(12'hA00, 8'h17, 8'h20, 16'h242C, 8'h37, 8'h20, 8'h00);
    addc(12'hFFF, 8'hFF, 8'h01, 16'h265F, 8'hFF, 8'h00, 8'h07);
    addc(12'h100, 8'h7F, 8'h01, 16'h2400, 8'h80, 8'h01, 8'h1A);
    bits_and_fill;
    absolute;
    freeze;
    apb(1'b0, 8'h24, 32'h0);
    chk(8'h24, {rd[30:0], er}, 32'h1);
    report_and_stop;
  end
  // far beyond the few hundred cycles the sequence needs
  initial
  begin
    #125000;
    mismatches++;
    report_and_stop;
  end
endmodule
